// ### hw/qdac_ctrl.v
// serial control logic of a quad 10-bit converter
// assumes serial pins asynchronous to i_core_clk, serial clock well below core clock / 4
// pins are sampled, so a frame costs a few core clocks of latency at its end
// no frame-length check: the last sixteen bits before deselect are the word
`timescale 1ns/1ps
`include "qdac_regs.vh"
module qdac_ctrl #(
    parameter CODE_W = `QDAC_CODE_W
) (
    // clock and reset
    input wire i_core_clk,
    input wire i_rst_n,
    // serial pins
    input wire i_cs_n,
    input wire i_sclk,
    input wire i_din,
    output reg o_dout_ff,
    // control pins
    input wire i_clear_all_n,
    input wire i_shutdown_lockout_n,
    output reg o_user_logic_output_ff,
    // converter codes and state
    output reg [4*CODE_W-1:0] o_dac_code_ff,
    output reg o_shutdown_ff
);
    reg [2:0] sync_ff;
    reg [2:0] sync2_ff;
    reg [1:0] clr_ff;
    reg [1:0] lock_ff;
    reg sclk_d_ff;
    reg cs_d_ff;
    reg [`QDAC_WORD_W-1:0] shift_ff;
    reg edge_mode_ff;
    reg [4*CODE_W-1:0] in_reg_ff;
    wire sclk_s = sync2_ff[0];
    wire cs_s = sync2_ff[1];
    wire din_s = sync2_ff[2];
    wire clr_n = clr_ff[1];
    wire lock_n = lock_ff[1];
    wire sclk_rise = sclk_s & ~sclk_d_ff;
    wire sclk_fall = ~sclk_s & sclk_d_ff;
    wire cs_rise = cs_s & ~cs_d_ff;
    wire [3:0] cmd = shift_ff[`QDAC_CMD_HI:`QDAC_CMD_LO];
    wire [CODE_W-1:0] data = shift_ff[`QDAC_DATA_HI:`QDAC_DATA_LO];
    wire [1:0] chan = cmd[3:2];
    localparam CHANS = 4;
    // serial pins: sync resets to idle levels so no false edge follows reset
    always @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sync_ff <= `QDAC_PIN_IDLE;
            sync2_ff <= `QDAC_PIN_IDLE;
        end else begin
            sync_ff <= {i_din, i_cs_n, i_sclk};
            sync2_ff <= sync_ff;
        end
    end
    // clear pin; resets low so clear also acts just after reset
    always @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            clr_ff <= 2'h0;
        end else begin
            clr_ff <= {clr_ff[0], i_clear_all_n};
        end
    end
    // lockout pin
    always @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            lock_ff <= 2'h0;
        end else begin
            lock_ff <= {lock_ff[0], i_shutdown_lockout_n};
        end
    end
    // frame-end decode shared by all channels
    wire cmd_load_all = (cmd == `QDAC_CMD_LOAD_ALL);
    wire cmd_load_upd = (cmd[1:0] == 2'h3);
    wire cmd_load_in = cmd[0];
    // mode codes refresh every converter as well
    wire cmd_update_all = cmd_load_upd || (cmd == `QDAC_CMD_UPDATE) ||
        (cmd == `QDAC_CMD_MODE1) || (cmd == `QDAC_CMD_MODE0);
    genvar g;
    generate
        for (g = 0; g < CHANS; g = g + 1) begin : g_chan
            reg [CODE_W-1:0] nxt_in;
            reg [CODE_W-1:0] nxt_code;
            wire own_chan = (chan == g);
            always @* begin
                nxt_in = in_reg_ff[g*CODE_W +: CODE_W];
                nxt_code = o_dac_code_ff[g*CODE_W +: CODE_W];
                if (!clr_n) begin
                    nxt_in = `QDAC_CODE_RESET;
                    nxt_code = `QDAC_CODE_RESET;
                end else if (cs_rise) begin
                    // input registers untouched by shutdown
                    if (cmd_load_in && own_chan) begin
                        nxt_in = data;
                    end else if (cmd_load_all) begin
                        nxt_in = data;
                    end
                    if (cmd_load_all) begin
                        nxt_code = data;
                    end else if (cmd_load_upd && own_chan) begin
                        // own channel takes new data, not stale input
                        nxt_code = data;
                    end else if (cmd_update_all) begin
                        nxt_code = in_reg_ff[g*CODE_W +: CODE_W];
                    end
                end
            end
            always @(posedge i_core_clk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    in_reg_ff[g*CODE_W +: CODE_W] <= `QDAC_CODE_RESET;
                    o_dac_code_ff[g*CODE_W +: CODE_W] <= `QDAC_CODE_RESET;
                end else begin
                    in_reg_ff[g*CODE_W +: CODE_W] <= nxt_in;
                    o_dac_code_ff[g*CODE_W +: CODE_W] <= nxt_code;
                end
            end
        end
    endgenerate
    reg [`QDAC_WORD_W-1:0] nxt_shift;
    reg nxt_dout;
    reg nxt_edge_mode;
    reg nxt_user_out;
    reg nxt_shutdown;
    // echo edge follows the programmed output mode; mode 0 means falling edge
    wire echo_edge = edge_mode_ff ? sclk_rise : sclk_fall;
    // edge detectors start at the idle pin levels
    always @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sclk_d_ff <= 1'b0;
            cs_d_ff <= 1'b1;
        end else begin
            sclk_d_ff <= sclk_s;
            cs_d_ff <= cs_s;
        end
    end
    // shift register, frozen while deselected
    always @* begin
        nxt_shift = shift_ff;
        if (!clr_n) begin
            nxt_shift = `QDAC_SHIFT_RESET;
        end else if (!cs_s && sclk_rise) begin
            nxt_shift = {shift_ff[`QDAC_WORD_W-2:0], din_s};
        end
    end
    // echo of the msb, also frozen while deselected
    always @* begin
        nxt_dout = o_dout_ff;
        if (!clr_n) begin
            nxt_dout = 1'b0;
        end else if (!cs_s && echo_edge) begin
            nxt_dout = shift_ff[`QDAC_WORD_W-1];
        end
    end
    // mode, user output and shutdown change only at frame end or clear
    always @* begin
        nxt_edge_mode = edge_mode_ff;
        nxt_user_out = o_user_logic_output_ff;
        nxt_shutdown = o_shutdown_ff;
        if (!clr_n) begin
            nxt_edge_mode = 1'b0;
            nxt_user_out = 1'b0;
            nxt_shutdown = 1'b0;
        end else if (cs_rise) begin
            case (cmd)
                `QDAC_CMD_SHUTDOWN: begin
                    if (lock_n) begin
                        nxt_shutdown = 1'b1;
                    end
                end
                `QDAC_CMD_UPDATE, `QDAC_CMD_LOAD_ALL: begin
                    nxt_shutdown = 1'b0;
                end
                `QDAC_CMD_UPO_LOW: begin
                    nxt_user_out = 1'b0;
                end
                `QDAC_CMD_UPO_HIGH: begin
                    nxt_user_out = 1'b1;
                end
                `QDAC_CMD_MODE1: begin
                    nxt_edge_mode = 1'b1;
                end
                `QDAC_CMD_MODE0: begin
                    nxt_edge_mode = 1'b0;
                end
                default: begin
                    if (cmd_load_upd) begin
                        nxt_shutdown = 1'b0;
                    end
                end
            endcase
        end
    end
    // serial state registers
    always @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            shift_ff <= `QDAC_SHIFT_RESET;
            o_dout_ff <= 1'b0;
        end else begin
            shift_ff <= nxt_shift;
            o_dout_ff <= nxt_dout;
        end
    end
    // mode and user output registers
    always @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            edge_mode_ff <= 1'b0;
            o_user_logic_output_ff <= 1'b0;
        end else begin
            edge_mode_ff <= nxt_edge_mode;
            o_user_logic_output_ff <= nxt_user_out;
        end
    end
    // shutdown register; setting it leaves the converter codes unchanged
    always @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_shutdown_ff <= 1'b0;
        end else begin
            o_shutdown_ff <= nxt_shutdown;
        end
    end
endmodule

// ### hw/qdac_regs.vh
// constants for the quad converter serial control block
// assumes inclusion by hw/qdac_ctrl.v only
`ifndef QDAC_REGS_VH
`define QDAC_REGS_VH
`define QDAC_WORD_W 16
`define QDAC_CODE_W 10
`define QDAC_CMD_HI 15
`define QDAC_CMD_LO 12
`define QDAC_DATA_HI 11
`define QDAC_DATA_LO 2
`define QDAC_CMD_NOP 4'h0
`define QDAC_CMD_UPDATE 4'h4
`define QDAC_CMD_LOAD_ALL 4'h8
`define QDAC_CMD_SHUTDOWN 4'hc
`define QDAC_CMD_UPO_LOW 4'h2
`define QDAC_CMD_UPO_HIGH 4'h6
`define QDAC_CMD_MODE1 4'he
`define QDAC_CMD_MODE0 4'ha
`define QDAC_CODE_RESET 10'h000
`define QDAC_SHIFT_RESET 16'h0000
`define QDAC_PIN_IDLE 3'h2
`endif

// ### testbench/qdac_ctrl_asserts.sv
// checker on the converter control ports
// assumes chip select stays high while clear is held
`timescale 1ns/1ps
module qdac_ctrl_asserts #(parameter CODE_W = 10) (
    input logic i_core_clk, i_rst_n, i_cs_n, o_dout_ff, i_clear_all_n, i_shutdown_lockout_n,
    input logic o_user_logic_output_ff, o_shutdown_ff,
    input logic [4*CODE_W-1:0] o_dac_code_ff
);
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);
    property p_clr; !i_clear_all_n [*5] |-> !{o_dac_code_ff, o_user_logic_output_ff, o_dout_ff, o_shutdown_ff}; endproperty
    a_clr: assert property (p_clr) else $error("clear ignored");
    property p_idle; (i_cs_n && i_clear_all_n) [*8] |=> $stable(o_dac_code_ff) && $stable(o_shutdown_ff); endproperty
    a_idle: assert property (p_idle) else $error("idle change");
    property p_code; !$stable(o_dac_code_ff) |-> i_cs_n && $past(i_cs_n, 2); endproperty
    a_code: assert property (p_code) else $error("code moved in frame");
    property p_sd; !$stable(o_shutdown_ff) |-> i_cs_n && $past(i_cs_n, 2); endproperty
    a_sd: assert property (p_sd) else $error("shutdown moved in frame");
    property p_upo; !$stable(o_user_logic_output_ff) |-> i_cs_n && $past(i_cs_n, 2); endproperty
    a_upo: assert property (p_upo) else $error("user output moved in frame");
    property p_lock; !i_shutdown_lockout_n [*6] |=> !$rose(o_shutdown_ff); endproperty
    a_lock: assert property (p_lock) else $error("shutdown while locked");
    property p_keep; $rose(o_shutdown_ff) |-> $stable(o_dac_code_ff); endproperty
    a_keep: assert property (p_keep) else $error("codes lost");
    property p_dout; !$stable(o_dout_ff) |-> !i_cs_n || !i_clear_all_n; endproperty
    a_dout: assert property (p_dout) else $error("echo moved idle");
    cover property ($rose(o_shutdown_ff));
    cover property ($fell(o_shutdown_ff));
    cover property ($rose(o_user_logic_output_ff));
endmodule
bind qdac_ctrl qdac_ctrl_asserts #(.CODE_W(CODE_W)) u_chk (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
    .i_cs_n(i_cs_n), .o_dout_ff(o_dout_ff), .i_clear_all_n(i_clear_all_n), .o_shutdown_ff(o_shutdown_ff),
    .i_shutdown_lockout_n(i_shutdown_lockout_n), .o_user_logic_output_ff(o_user_logic_output_ff),
    .o_dac_code_ff(o_dac_code_ff));

// ### testbench/qdac_ctrl_tb_top.sv
// bench for the converter control block
// assumes the master model drives the serial pins
`timescale 1ns/1ps
`define CHK(n, e, s) begin n_tests++; if ((s) !== (e)) begin errors++; $display("[ERR] %s exp %0h got %0h", n, e, s); end end
module qdac_ctrl_tb_top;
    logic i_core_clk = 0, i_rst_n = 0, i_clear_all_n = 1, i_shutdown_lockout_n = 1, m1 = 0;
    wire i_cs_n, i_sclk, i_din, o_dout_ff, o_user_logic_output_ff, o_shutdown_ff;
    wire [39:0] o_dac_code_ff;
    wire [41:0] seen = {o_shutdown_ff, o_user_logic_output_ff, o_dac_code_ff};
    int errors = 0, n_tests = 0;
    logic [15:0] prev = 0, echo;
    logic [15:0] w_tab [14] = '{16'h1554, 16'h7aa8, 16'h9004, 16'hf800, 16'h5000, 16'h4000, 16'h6000,
        16'he000, 16'ha000, 16'h2000, 16'h8ffc, 16'h0000, 16'hc000, 16'h3004};
    logic [41:0] x_tab [14] = '{0, 42'haa955, 42'haa955, 42'h80001aa955, 42'h80001aa955, 42'h8000100155,
        42'h18000100155, 42'h18000100155, 42'h18000100155, 42'h8000100155, 42'hffffffffff,
        42'hffffffffff, 42'h2ffffffffff, 42'hfffffffc01};
    always #20 i_core_clk = ~i_core_clk;
    qdac_ctrl uut (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_cs_n(i_cs_n), .i_sclk(i_sclk), .i_din(i_din),
        .o_dout_ff(o_dout_ff), .i_clear_all_n(i_clear_all_n), .i_shutdown_lockout_n(i_shutdown_lockout_n),
        .o_user_logic_output_ff(o_user_logic_output_ff), .o_dac_code_ff(o_dac_code_ff), .o_shutdown_ff(o_shutdown_ff));
    qdac_master m (.o_cs_n(i_cs_n), .o_sclk(i_sclk), .o_din(i_din), .i_dout(o_dout_ff));
    task automatic frame(input logic [15:0] w);
        m.send(w, echo);
        // echo timing differs in rising-edge mode
        if (!m1) `CHK("echo", {prev[14:0], w[15]}, echo)
        else `CHK("echo1", prev, echo)
        prev = w;
        m1 = (w[15:12] == 4'he) ? 1'b1 : (w[15:12] == 4'ha) ? 1'b0 : m1;
        repeat (8) @(negedge i_core_clk);
    endtask
    task report_and_stop;
        $display("checks %0d errors %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        #2000000 errors++;
        report_and_stop;
    end
    initial begin
        repeat (20) @(negedge i_core_clk);
        i_rst_n = 1;
        repeat (4) @(negedge i_core_clk);
        foreach (w_tab[r]) begin
            frame(w_tab[r]);
            `CHK("outputs", x_tab[r], seen)
        end
        i_shutdown_lockout_n = 0;
        frame(16'hc000);
        `CHK("locked", 42'hfffffffc01, seen)
        i_shutdown_lockout_n = 1;
        frame(16'hc000);
        frame(16'h1008);
        `CHK("kept", 42'h2fffffffc01, seen)
        frame(16'h4000);
        `CHK("restored", 42'hfffffffc02, seen)
        m.noise();
        repeat (8) @(negedge i_core_clk);
        `CHK("idle", 42'hfffffffc02, seen)
        frame(16'h6000);
        frame(16'h8ffc);
        i_clear_all_n = 0;
        repeat (8) @(negedge i_core_clk);
        `CHK("clear", 43'h0, {o_dout_ff, seen})
        report_and_stop;
    end
endmodule

// ### testbench/qdac_master.sv
// serial master model, 480 ns link clock
// assumes calls start on a core clock falling edge
`timescale 1ns/1ps
module qdac_master (
    // serial pins
    output logic o_cs_n,
    output logic o_sclk,
    output logic o_din,
    input logic i_dout
);
    initial {o_cs_n, o_sclk, o_din} = 3'b100;
    task automatic send(input logic [15:0] w, output logic [15:0] echo);
        o_cs_n = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            o_din = w[i];
            #160 o_sclk = 1'b1;
            #160 o_sclk = 1'b0;
            #160 echo[i] = i_dout;
        end
        o_cs_n = 1'b1;
        // released line shows the inverse, not a stale bit
        o_din = ~o_din;
    endtask
    task automatic noise();
        for (int i = 0; i < 8; i++) begin
            o_din = ~o_din;
            #160 o_sclk = ~o_sclk;
        end
    endtask
endmodule
